// *** amc_ctrl.sv ***
// Mode decode, align, per-channel sleep and output slot control of the converter
// What this block does
// - Decode rate profile into conversion period
// - SPI: ready held high after profile change
// - Frame mode: outputs low until settled
// - Align low halts, clears filter counters
// - Align high restarts all channels together
// - Align sampled on master clock
// - SPI: ready high during align, settling
// - Frame mode: outputs low during align, settling
// - Sleep after two low clocks, wake high
// - All asleep: micropower, outputs still driven
// - SPI: all asleep forces ready high
// - Woken channel valid after fixed settle
// - Running channels unaffected by wake
// - Woken channels join running phase
// - Fixed slots zero; dynamic slots pack
// - Discrete: sleeping channels output zeros
// - Dynamic: waking channel joins when valid
// - Decode three-bit output format
// - Profile watched continuously, acted on
`timescale 1ns/10ps
module amc_ctrl #(
  parameter int CHANNELS = 8,
  parameter int DATA_W   = 24
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  wire logic [1:0]               rate_select,
  input  wire logic                     clock_ratio_select,
  input  wire logic [2:0]               format_select,
  input  wire logic                     align_n,
  input  wire logic [CHANNELS-1:0]      channel_sleep_n,
  input  wire logic                     frame_strobe,
  input  wire logic [CHANNELS*DATA_W-1:0] raw_data,
  output logic                          conv_tick,
  output logic                          result_ready_n,
  output logic [CHANNELS*DATA_W-1:0]    slot_data,
  output logic [CHANNELS-1:0]           slot_valid,
  output logic                          frame_out_valid,
  input  wire logic                     frame_out_ready,
  output logic [CHANNELS-1:0]           frame_slot_zero,
  output logic                          micropower,
  output logic                          format_frame,
  output logic                          format_discrete,
  output logic                          format_dynamic,
  output logic                          format_illegal
);

  // ***************************************************************
  // Checks
  // ***************************************************************
  initial begin
    if (CHANNELS < 1 || CHANNELS > 8) $error("amc_ctrl channel count out of range");
    if (DATA_W < 1) $error("amc_ctrl data width too small");
  end

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  localparam int SYNC_W = 2 + 1 + 3 + 1 + CHANNELS + 1;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [1:0]        rate_s;
  logic              ratio_s;
  logic [2:0]        format_s;
  logic              align_s;
  logic [CHANNELS-1:0] sleep_s;
  logic              strobe_s;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_a <= '1;
      sync_b <= '1;
    end else begin
      sync_a <= {rate_select, clock_ratio_select, format_select, align_n, channel_sleep_n, frame_strobe};
      sync_b <= sync_a;
    end
  end

  assign {rate_s, ratio_s, format_s, align_s, sleep_s, strobe_s} = sync_b;

  // ***************************************************************
  // Format decode
  // ***************************************************************
  always_comb begin
    format_frame    = 1'b0;
    format_discrete = 1'b0;
    format_dynamic  = 1'b0;
    format_illegal  = 1'b0;
    unique case (format_s)
      3'h0: begin
        format_dynamic = 1'b1;
      end
      3'h1: begin
      end
      3'h2: begin
        format_discrete = 1'b1;
      end
      3'h3: begin
        format_frame   = 1'b1;
        format_dynamic = 1'b1;
      end
      3'h4: begin
        format_frame = 1'b1;
      end
      3'h5: begin
        format_frame    = 1'b1;
        format_discrete = 1'b1;
      end
      default: begin
        format_illegal = 1'b1;
      end
    endcase
  end

  // ***************************************************************
  // Rate decode and conversion divider
  // ***************************************************************
  logic [amc_pkg::AMC_DIV_W-1:0] period;
  logic [amc_pkg::AMC_DIV_W-1:0] div_cnt;
  logic [1:0]                    rate_prev;
  logic                          rate_change;
  logic                          align_prev;
  logic                          align_fall;
  logic                          align_rise;
  logic                          halted;

  always_comb begin
    period = amc_pkg::AMC_DIV_W'(amc_pkg::AMC_DIV_HS);
    unique case (amc_pkg::amc_rate_t'(rate_s))
      amc_pkg::AMC_RATE_HIGH_SPEED: period = amc_pkg::AMC_DIV_W'(amc_pkg::AMC_DIV_HS);
      amc_pkg::AMC_RATE_HIGH_RES:   period = amc_pkg::AMC_DIV_W'(amc_pkg::AMC_DIV_HR);
      amc_pkg::AMC_RATE_LOW_POWER:  period = ratio_s ? amc_pkg::AMC_DIV_W'(amc_pkg::AMC_DIV_LP_FULL)
                                                     : amc_pkg::AMC_DIV_W'(amc_pkg::AMC_DIV_LP_HALF);
      amc_pkg::AMC_RATE_LOW_SPEED:  period = ratio_s ? amc_pkg::AMC_DIV_W'(amc_pkg::AMC_DIV_LS_FULL)
                                                     : amc_pkg::AMC_DIV_W'(amc_pkg::AMC_DIV_LS_HALF);
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rate_prev  <= 2'h0;
      align_prev <= 1'b1;
    end else begin
      rate_prev  <= rate_s;
      align_prev <= align_s;
    end
  end

  assign rate_change = (rate_s != rate_prev);
  assign align_fall  = align_prev && !align_s;
  assign align_rise  = !align_prev && align_s;
  assign halted      = !align_s;

  // Frame-aligned restart: in frame mode ticks follow the strobe rising edge
  logic strobe_prev;
  logic strobe_rise;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strobe_prev <= 1'b1;
    end else begin
      strobe_prev <= strobe_s;
    end
  end
  assign strobe_rise = strobe_s && !strobe_prev;

  always_ff @(posedge sys_clk) begin
    if (reset || halted || rate_change) begin
      div_cnt <= '0;
    end else if (format_frame && strobe_rise) begin
      div_cnt <= '0;
    end else if (div_cnt >= period - amc_pkg::AMC_DIV_W'(1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + amc_pkg::AMC_DIV_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || halted) begin
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= (div_cnt == period - amc_pkg::AMC_DIV_W'(1));
    end
  end

  // ***************************************************************
  // Global filter settling after profile change or align
  // ***************************************************************
  logic [amc_pkg::AMC_SETTLE_W-1:0] settle_cnt;
  logic [amc_pkg::AMC_SETTLE_W-1:0] settle_max;
  logic                             settled;

  assign settle_max = format_frame ? amc_pkg::AMC_SETTLE_W'(amc_pkg::AMC_SETTLE_FS)
                                   : amc_pkg::AMC_SETTLE_W'(amc_pkg::AMC_SETTLE_SPI);

  always_ff @(posedge sys_clk) begin
    if (reset || halted || rate_change || align_fall) begin
      settle_cnt <= '0;
    end else if (conv_tick && settle_cnt != settle_max) begin
      settle_cnt <= settle_cnt + amc_pkg::AMC_SETTLE_W'(1);
    end
  end

  assign settled = (settle_cnt == settle_max);

  // ***************************************************************
  // Per-channel sleep and wake settling
  // ***************************************************************
  logic [CHANNELS-1:0] awake;
  logic [CHANNELS-1:0] ch_valid;
  logic [amc_pkg::AMC_SETTLE_W-1:0] wake_max;

  assign wake_max = format_frame ? amc_pkg::AMC_SETTLE_W'(amc_pkg::AMC_WAKE_FS)
                                 : amc_pkg::AMC_SETTLE_W'(amc_pkg::AMC_WAKE_SPI);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic [1:0]                       low_cnt;
      logic [amc_pkg::AMC_SETTLE_W-1:0] wake_cnt;

      always_ff @(posedge sys_clk) begin
        if (reset) begin
          low_cnt <= 2'h0;
          awake[g] <= amc_pkg::AMC_RESET_AWAKE[g];
        end else if (sleep_s[g]) begin
          low_cnt  <= 2'h0;
          awake[g] <= 1'b1;
        end else if (low_cnt < 2'(amc_pkg::AMC_SLEEP_MIN - 1)) begin
          low_cnt <= low_cnt + 2'h1;
        end else begin
          awake[g] <= 1'b0;
        end
      end

      // Wake counting runs on the shared tick, so it lands in step
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          wake_cnt <= wake_max;
        end else if (!awake[g]) begin
          wake_cnt <= '0;
        end else if (conv_tick && wake_cnt < wake_max) begin
          wake_cnt <= wake_cnt + amc_pkg::AMC_SETTLE_W'(1);
        end
      end

      assign ch_valid[g] = awake[g] && (wake_cnt >= wake_max) && settled;
    end
  endgenerate

  assign micropower = (awake == '0);

  // ***************************************************************
  // Result ready and slot building
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      result_ready_n <= 1'b1;
    end else if (format_frame || micropower || !settled || halted) begin
      result_ready_n <= 1'b1;
    end else if (conv_tick && (ch_valid != '0)) begin
      result_ready_n <= 1'b0;
    end
  end

  // Slot building: zero fill for fixed and discrete, pack for dynamic
  logic [CHANNELS*DATA_W-1:0] next_slot_data;
  logic [CHANNELS-1:0]        next_slot_valid;
  logic [3:0]                 pos;
  always_comb begin
    next_slot_data  = '0;
    next_slot_valid = '0;
    pos             = 4'h0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (format_dynamic && !format_discrete) begin
        if (ch_valid[i]) begin
          next_slot_data[pos*DATA_W +: DATA_W] = raw_data[i*DATA_W +: DATA_W];
          next_slot_valid[pos[2:0]]            = 1'b1;
          pos                                  = pos + 4'h1;
        end
      end else begin
        next_slot_valid[i] = ch_valid[i];
        if (ch_valid[i]) begin
          next_slot_data[i*DATA_W +: DATA_W] = raw_data[i*DATA_W +: DATA_W];
        end
      end
    end
  end

  // Data held until the buffer accepts; low until settled in frame mode
  amc_pkg::amc_frame_t desc_in;
  amc_pkg::amc_frame_t desc_out;
  logic                desc_ready;
  logic                desc_push;

  assign desc_push = conv_tick && !micropower && settled;

  always_ff @(posedge sys_clk) begin
    if (reset || halted || !settled) begin
      slot_data  <= '0;
      slot_valid <= '0;
    end else if (desc_push && desc_ready) begin
      slot_data  <= next_slot_data;
      slot_valid <= next_slot_valid;
    end
  end

  always_comb begin
    desc_in            = '0;
    desc_in.slot_valid = 8'(next_slot_valid);
    desc_in.slot_zero  = 8'(~ch_valid);
    desc_in.frame_mode = format_frame;
    desc_in.discrete   = format_discrete;
    desc_in.dynamic    = format_dynamic;
  end

  amc_buf2 #(
    .WIDTH ($bits(amc_pkg::amc_frame_t))
  ) u_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (desc_push),
    .in_ready  (desc_ready),
    .in_data   (desc_in),
    .out_valid (frame_out_valid),
    .out_ready (frame_out_ready),
    .out_data  (desc_out)
  );

  assign frame_slot_zero = desc_out.slot_zero[CHANNELS-1:0];

endmodule

// *** amc_pkg.sv ***
// Package of constants and types for the converter mode, align and sleep control
package amc_pkg;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  typedef enum logic [1:0] {
    AMC_RATE_HIGH_SPEED = 2'b00,
    AMC_RATE_HIGH_RES   = 2'b01,
    AMC_RATE_LOW_POWER  = 2'b10,
    AMC_RATE_LOW_SPEED  = 2'b11
  } amc_rate_t;

  typedef enum logic [2:0] {
    AMC_FMT_SPI_TDM_DYN = 3'b000,
    AMC_FMT_SPI_TDM_FIX = 3'b001,
    AMC_FMT_SPI_DISC    = 3'b010,
    AMC_FMT_FS_TDM_DYN  = 3'b011,
    AMC_FMT_FS_TDM_FIX  = 3'b100,
    AMC_FMT_FS_DISC     = 3'b101
  } amc_format_t;

  // ***************************************************************
  // Counts
  // ***************************************************************
  // Master clock cycles per conversion, per profile and clock ratio
  localparam int AMC_DIV_HS       = 256;
  localparam int AMC_DIV_HR       = 512;
  localparam int AMC_DIV_LP_FULL  = 512;
  localparam int AMC_DIV_LP_HALF  = 256;
  localparam int AMC_DIV_LS_FULL  = 2560;
  localparam int AMC_DIV_LS_HALF  = 512;
  localparam int AMC_DIV_W        = 12;

  // Settling in conversion periods
  localparam int AMC_SETTLE_SPI   = 129;
  localparam int AMC_SETTLE_FS    = 128;
  localparam int AMC_WAKE_SPI     = 130;
  localparam int AMC_WAKE_FS      = 129;
  localparam int AMC_SETTLE_W     = 8;

  // Sleep input must stand low this many master clocks
  localparam int AMC_SLEEP_MIN    = 2;

  // Link clock period, 400 ns against 50 ns system clock
  localparam int AMC_SYS_PERIOD_NS  = 50;
  localparam int AMC_LINK_PERIOD_NS = 400;
  localparam int AMC_LINK_CYCLES    = (AMC_LINK_PERIOD_NS + AMC_SYS_PERIOD_NS - 1) / AMC_SYS_PERIOD_NS;

  localparam logic [7:0] AMC_RESET_AWAKE = 8'hff;

  // ***************************************************************
  // Carried bundles
  // ***************************************************************
  typedef struct packed {
    logic [7:0]  slot_valid;
    logic [7:0]  slot_zero;
    logic        frame_mode;
    logic        discrete;
    logic        dynamic;
  } amc_frame_t;

endpackage

// *** amc_buf2.sv ***
// Two-entry valid/ready buffer for frame descriptors
`timescale 1ns/10ps
module amc_buf2 #(
  parameter int WIDTH = 19
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // ***************************************************************
  // Storage
  // ***************************************************************
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  initial begin
    if (WIDTH < 1) $error("amc_buf2 width too small");
  end

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// *** amc_ctrl_chk.sv ***
// Checker for mode decode, align, sleep and slot behaviour
`timescale 1ns/10ps
module amc_ctrl_chk #(
  parameter int CHANNELS = 8,
  parameter int DATA_W   = 24
) (
  input wire logic                         sys_clk,
  input wire logic                         reset,
  input wire logic [1:0]                   rate_select,
  input wire logic                         clock_ratio_select,
  input wire logic [2:0]                   format_select,
  input wire logic                         align_n,
  input wire logic [CHANNELS-1:0]          channel_sleep_n,
  input wire logic                         frame_strobe,
  input wire logic [CHANNELS*DATA_W-1:0]   raw_data,
  input wire logic                         conv_tick,
  input wire logic                         result_ready_n,
  input wire logic [CHANNELS*DATA_W-1:0]   slot_data,
  input wire logic [CHANNELS-1:0]          slot_valid,
  input wire logic                         frame_out_valid,
  input wire logic                         frame_out_ready,
  input wire logic [CHANNELS-1:0]          frame_slot_zero,
  input wire logic                         micropower,
  input wire logic                         format_frame,
  input wire logic                         format_discrete,
  input wire logic                         format_dynamic,
  input wire logic                         format_illegal
);
  logic [11:0] gap;
  logic [1:0]  tks;
  logic [7:0]  st;
  logic [2:0]  cfg_q;
  logic        cfg_chg;
  logic        zero_ok;
  int          exp_p;

  // ***************************************************************
  // Helper counters
  // ***************************************************************
  assign cfg_chg = (cfg_q != {rate_select, clock_ratio_select}) || !align_n || frame_strobe || (channel_sleep_n == '0);

  always_comb begin
    case (rate_select)
      2'b00:   exp_p = amc_pkg::AMC_DIV_HS;
      2'b01:   exp_p = amc_pkg::AMC_DIV_HR;
      2'b10:   exp_p = clock_ratio_select ? amc_pkg::AMC_DIV_LP_FULL : amc_pkg::AMC_DIV_LP_HALF;
      default: exp_p = clock_ratio_select ? amc_pkg::AMC_DIV_LS_FULL : amc_pkg::AMC_DIV_LS_HALF;
    endcase
  end

  always_comb begin
    zero_ok = 1'b1;
    for (int i = 0; i < CHANNELS; i++) begin
      if (!slot_valid[i] && slot_data[i*DATA_W +: DATA_W] != '0) begin
        zero_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    cfg_q <= {rate_select, clock_ratio_select};
    if (reset || cfg_chg) begin
      gap <= 12'h000;
      tks <= 2'h0;
      st  <= 8'h00;
    end else if (conv_tick) begin
      gap <= 12'h001;
      tks <= (tks == 2'h3) ? tks : tks + 2'h1;
      st  <= (st == 8'hff) ? st : st + 8'h01;
    end else begin
      gap <= gap + 12'h001;
    end
  end

  // ***************************************************************
  // Properties
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_steady_tick;
    conv_tick && tks == 2'h3;
  endsequence
  sequence s_align_held;
    (!align_n && !format_frame) [*5];
  endsequence
  sequence s_all_asleep;
    (channel_sleep_n == '0) [*8];
  endsequence

  AST_TICK_PERIOD: assert property (s_steady_tick |-> gap == exp_p)
    else $error("conversion period differs from profile");
  AST_READY_ALIGN: assert property ($fell(align_n) && !format_frame |-> ##[1:4] result_ready_n)
    else $error("ready not raised on align");
  AST_ZERO_ALIGN: assert property ($fell(align_n) && format_frame |-> ##[1:5] slot_data == '0)
    else $error("frame data not cleared on align");
  AST_HALT: assert property (!align_n [*5] |-> !conv_tick)
    else $error("tick during align");
  AST_READY_HOLD: assert property (s_align_held |-> result_ready_n)
    else $error("ready low during align");
  AST_READY_EARLY: assert property ($fell(result_ready_n) |-> st >= 8'd128)
    else $error("ready before settling");
  AST_READY_LATE: assert property (st >= 8'd131 && !format_frame && align_n |-> !result_ready_n)
    else $error("ready missing after settling");
  AST_ALL_ASLEEP: assert property (s_all_asleep |-> micropower && result_ready_n)
    else $error("all asleep not signalled");
  AST_AWAKE: assert property ((channel_sleep_n != '0) [*8] |-> !micropower)
    else $error("micropower while a channel is awake");
  AST_SLOT_ZERO: assert property (conv_tick && !format_dynamic |-> ##2 zero_ok)
    else $error("empty slot carries data");
  AST_DYN_PACK: assert property (conv_tick && format_dynamic |-> ##2 ((slot_valid + 1'b1) & slot_valid) == '0)
    else $error("dynamic slots not packed");
  AST_FMT: assert property ($stable(format_select) [*4] |-> format_frame == (format_select inside {3'h3, 3'h4, 3'h5}))
    else $error("format decode wrong");
endmodule

// *** amc_host_model.sv ***
// Host side model: frame strobe source, data sink, raw word source
`timescale 1ns/10ps
module amc_host_model #(
  parameter int CHANNELS = 8,
  parameter int DATA_W   = 24,
  parameter int FRAME    = 256
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  wire logic                     stall,
  input  wire logic                     strobe_on,
  output logic                          frame_strobe,
  output logic                          frame_out_ready,
  output logic [CHANNELS*DATA_W-1:0]    raw_data
);
  int fcnt;

  // Strobe runs only while frames are wanted
  always_ff @(posedge sys_clk) begin
    if (reset || !strobe_on) begin
      fcnt         <= 0;
      frame_strobe <= 1'b0;
    end else begin
      fcnt         <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
      frame_strobe <= (fcnt < 4);
    end
  end

  // Sink stalls only on command
  assign frame_out_ready = !stall;

  // Nonzero word per channel
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      raw_data[i*DATA_W +: DATA_W] = {(DATA_W / 8){8'(i + 1)}};
    end
  end
endmodule

// *** amc_ctrl_test.sv ***
// Self-checking bench for mode, align and sleep control
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module amc_ctrl_test;
  logic         sys_clk            = 1'b0;
  logic         reset              = 1'b1;
  logic [1:0]   rate_select        = 2'b00;
  logic         clock_ratio_select = 1'b1;
  logic [2:0]   format_select      = 3'b001;
  logic         align_n            = 1'b1;
  logic [7:0]   channel_sleep_n    = 8'hff;
  logic         stall              = 1'b0;
  logic         strobe_on          = 1'b0;
  logic         frame_strobe;
  logic         frame_out_ready;
  logic [191:0] raw_data;
  logic         conv_tick;
  logic         result_ready_n;
  logic [191:0] slot_data;
  logic [7:0]   slot_valid;
  logic         frame_out_valid;
  logic [7:0]   frame_slot_zero;
  logic         micropower;
  logic         format_frame, format_discrete, format_dynamic, format_illegal;
  logic [3:0]   e;
  logic [1:0]   rt [6] = '{2'b00, 2'b01, 2'b10, 2'b10, 2'b11, 2'b11};
  logic         rc [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  int           rp [6] = '{256, 512, 512, 256, 2560, 512};
  int           mismatches = 0;
  int           samples_checked = 0;
  int           n;

  always #25 sys_clk = ~sys_clk;

  amc_ctrl #(.CHANNELS(8), .DATA_W(24)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .rate_select(rate_select), .clock_ratio_select(clock_ratio_select),
    .format_select(format_select), .align_n(align_n), .channel_sleep_n(channel_sleep_n),
    .frame_strobe(frame_strobe), .raw_data(raw_data), .conv_tick(conv_tick), .result_ready_n(result_ready_n),
    .slot_data(slot_data), .slot_valid(slot_valid), .frame_out_valid(frame_out_valid),
    .frame_out_ready(frame_out_ready), .frame_slot_zero(frame_slot_zero), .micropower(micropower),
    .format_frame(format_frame), .format_discrete(format_discrete), .format_dynamic(format_dynamic),
    .format_illegal(format_illegal));

  amc_host_model #(.CHANNELS(8), .DATA_W(24), .FRAME(256)) u_host (
    .sys_clk(sys_clk), .reset(reset), .stall(stall), .strobe_on(strobe_on), .frame_strobe(frame_strobe),
    .frame_out_ready(frame_out_ready), .raw_data(raw_data));

  // ***************************************************************
  // Pin access tasks
  // ***************************************************************
  task automatic pins(input logic [1:0] r, input logic c, input logic [2:0] f);
    @(posedge sys_clk);
    rate_select <= r;
    clock_ratio_select <= c;
    format_select <= f;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic tick(input int k);
    int w;
    repeat (k) begin
      w = 0;
      do begin
        @(posedge sys_clk);
        w++;
      end while (conv_tick !== 1'b1 && w < 3000);
    end
  endtask

  task automatic gap(output int g);
    tick(1);
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
    end while (conv_tick !== 1'b1 && g < 3000);
  endtask

  task automatic align_low();
    @(posedge sys_clk);
    align_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic close_out();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (int f = 0; f < 8; f++) begin
      pins(2'b00, 1'b1, 3'(f));
      e = {f inside {3, 4, 5}, f == 2 || f == 5, f == 0 || f == 3, f > 5};
      `CHK({format_frame, format_discrete, format_dynamic, format_illegal}, e)
    end
    for (int i = 0; i < 6; i++) begin
      pins(rt[i], rc[i], 3'b001);
      tick(1);
      gap(n);
      `CHK(n, rp[i])
    end
    pins(2'b00, 1'b1, 3'b001);
    align_low();
    `CHK(result_ready_n, 1'b1)
    align_n <= 1'b1;
    n = 0;
    while (result_ready_n !== 1'b0 && n < 140) begin
      tick(1);
      n++;
    end
    `CHK(n >= 128 && n <= 131, 1'b1)
    tick(2);
    `CHK(slot_valid, 8'hff)
    `CHK(slot_data, raw_data)
    stall <= 1'b1;
    tick(4);
    `CHK(frame_out_valid, 1'b1)
    `CHK(frame_slot_zero, 8'h00)
    stall <= 1'b0;
    n = 0;
    repeat (20) begin
      @(posedge sys_clk);
      if (frame_out_valid === 1'b1 && frame_out_ready === 1'b1) n++;
    end
    `CHK(n, 2)
    `CHK(frame_out_valid, 1'b0)
    channel_sleep_n <= 8'hfd;
    for (int f = 0; f < 3; f++) begin
      pins(2'b00, 1'b1, 3'(f));
      tick(2);
      @(posedge sys_clk);
      `CHK(slot_valid, f == 0 ? 8'h7f : 8'hfd)
      `CHK(slot_data[47:24], f == 0 ? raw_data[71:48] : 24'h000000)
      `CHK(result_ready_n, 1'b0)
    end
    channel_sleep_n <= 8'hff;
    tick(10);
    `CHK(slot_valid, 8'hfd)
    `CHK(slot_data[47:24], 24'h000000)
    `CHK(result_ready_n, 1'b0)
    n = 10;
    while (slot_valid[1] !== 1'b1 && n < 140) begin
      tick(1);
      n++;
    end
    `CHK(n >= 129 && n <= 132, 1'b1)
    `CHK(slot_data[71:24], raw_data[71:24])
    channel_sleep_n <= 8'h00;
    repeat (8) @(posedge sys_clk);
    `CHK(micropower, 1'b1)
    `CHK(result_ready_n, 1'b1)
    channel_sleep_n <= 8'hff;
    strobe_on <= 1'b1;
    pins(2'b00, 1'b1, 3'b100);
    tick(2);
    align_low();
    `CHK(slot_data, 192'h0)
    align_n <= 1'b1;
    tick(3);
    `CHK(slot_data, 192'h0)
    close_out();
  end

  initial begin
    #4750000;
    mismatches++;
    close_out();
  end
endmodule

bind amc_ctrl amc_ctrl_chk #(.CHANNELS(CHANNELS), .DATA_W(DATA_W)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .rate_select(rate_select), .clock_ratio_select(clock_ratio_select),
  .format_select(format_select), .align_n(align_n), .channel_sleep_n(channel_sleep_n),
  .frame_strobe(frame_strobe), .raw_data(raw_data), .conv_tick(conv_tick), .result_ready_n(result_ready_n),
  .slot_data(slot_data), .slot_valid(slot_valid), .frame_out_valid(frame_out_valid),
  .frame_out_ready(frame_out_ready), .frame_slot_zero(frame_slot_zero), .micropower(micropower),
  .format_frame(format_frame), .format_discrete(format_discrete), .format_dynamic(format_dynamic),
  .format_illegal(format_illegal));
